// file: verilog/iwr_pkg.sv
// package for the interrupt wake-and-return block: register map, fields, timing, types
// assumes a 32-bit classic wishbone slave port with byte addressing
package iwr_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, one aligned word each)
  // ----------------------------------------------------------------
  localparam int unsigned   WB_AW        = 8;
  localparam logic [7:0]    OFS_CTRL     = 8'h00;
  localparam logic [7:0]    OFS_ENABLE   = 8'h04;
  localparam logic [7:0]    OFS_FLAGS    = 8'h08;
  localparam logic [7:0]    OFS_SUBFLAGS = 8'h0C;
  localparam logic [7:0]    OFS_STATUS   = 8'h10;
  localparam logic [7:0]    OFS_MASK     = 8'h14;
  localparam logic [7:0]    OFS_STACK    = 8'h18;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned   CTRL_GIE_BIT    = 0;
  localparam logic          GIE_RESET       = 1'b0;
  localparam int unsigned   NUM_EVENTS      = 4;
  localparam int unsigned   EV_WAKE_BIT     = 0;
  localparam int unsigned   EV_ENTRY_BIT    = 1;
  localparam int unsigned   EV_RETURN_BIT   = 2;
  localparam int unsigned   EV_OVERFLOW_BIT = 3;
  localparam logic [31:0]   DATA_ZERO       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned   CLKS_PER_INSTR  = 4;
  localparam int unsigned   RETURN_INSTRS   = 2;
  localparam int unsigned   RETURN_CLKS     = CLKS_PER_INSTR * RETURN_INSTRS;
  localparam logic [3:0]    RETURN_LOAD     = 4'(RETURN_CLKS - 1);
  localparam logic [3:0]    CNT_ZERO        = 4'h0;
  localparam logic [3:0]    CNT_ONE         = 4'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_RETURN = 2'b10
  } iwr_state_t;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [WB_AW-1:0] adr;
    logic [7:0]       dat;
  } iwr_bus_req_t;

  typedef struct packed {
    logic busy;
    logic restore_gie;
  } iwr_ret_t;

endpackage

// file: verilog/iwr_flag_bank.sv
// sticky request flags, one per bit, with hardware set, service clear and software write
// assumes set and clear inputs are synchronous one-cycle pulses
`timescale 1ns/1ps
module iwr_flag_bank #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // flag controls
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] hw_clr_i,
  input  wire logic         sw_we_i,
  input  wire logic [W-1:0] sw_dat_i,
  // flag state
  output logic      [W-1:0] flag_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // hold until cleared
      // a set arriving with a clear wins, so no event is lost
      always_comb begin
        flag_next[g] = flag_reg[g];
        if (sw_we_i) begin
          flag_next[g] = sw_dat_i[g];
        end
        if (hw_clr_i[g]) begin
          flag_next[g] = 1'b0;
        end
        if (set_i[g]) begin
          flag_next[g] = 1'b1;
        end
      end
      assign rise_o[g] = flag_next[g] & ~flag_reg[g];
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

endmodule

// file: verilog/iwr_top.sv
// interrupt request flags, wake-up, vector arbitration, return stack and return timing
// assumes a core that acknowledges vector requests and issues call and return pulses
`timescale 1ns/1ps
module iwr_top
  import iwr_pkg::*;
#(
  parameter int unsigned NUM_SRC     = 4,
  parameter int unsigned NUM_SUB     = 4,
  parameter int unsigned PC_W        = 12,
  parameter int unsigned STACK_DEPTH = 4
) (
  // clock and reset
  input  wire logic                         CLOCK_I,
  input  wire logic                         RESET_I,
  // wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [WB_AW-1:0]             WB_ADR_I,
  input  wire logic [3:0]                   WB_SEL_I,
  input  wire logic [31:0]                  WB_DAT_I,
  output logic      [31:0]                  WB_DAT_O,
  output logic                              WB_ACK_O,
  // peripheral request pulses
  input  wire logic [NUM_SRC-1:0]           SRC_SET_I,
  input  wire logic [NUM_SUB-1:0]           SUB_SET_I,
  // core side
  input  wire logic                         SLEEP_I,
  input  wire logic [PC_W-1:0]              PC_I,
  input  wire logic                         CALL_I,
  input  wire logic                         RET_I,
  input  wire logic                         RETURN_FROM_INTERRUPT_I,
  input  wire logic                         VEC_ACK_I,
  output logic                              WAKE_O,
  output logic                              VEC_REQ_O,
  output logic      [$clog2(NUM_SRC+1)-1:0] VEC_IDX_O,
  output logic                              RET_DONE_O,
  output logic      [PC_W-1:0]              RET_PC_O,
  output logic                              GIE_O,
  output logic                              STACK_FULL_O,
  // interrupt to software
  output logic                              IRQ_O
);

  localparam int unsigned NV   = NUM_SRC + 1;
  localparam int unsigned IW   = $clog2(NV);
  localparam int unsigned SPW  = $clog2(STACK_DEPTH + 1);
  localparam int unsigned SIW  = $clog2(STACK_DEPTH);
  localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);
  localparam logic [SPW-1:0] SP_ONE  = SPW'(1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                  ack_reg,     ack_next;
  logic [31:0]           rdat_reg,    rdat_next;
  logic                  gie_reg,     gie_next;
  logic [NV-1:0]         en_reg,      en_next;
  logic [NUM_EVENTS-1:0] status_reg,  status_next;
  logic [NUM_EVENTS-1:0] mask_reg,    mask_next;
  logic                  irq_reg,     irq_next;
  logic                  wake_reg,    wake_next;
  logic                  vreq_reg,    vreq_next;
  logic [IW-1:0]         vidx_reg,    vidx_next;
  logic                  done_reg,    done_next;
  logic [PC_W-1:0]       rpc_reg,     rpc_next;
  logic [SPW-1:0]        sp_reg,      sp_next;
  logic [3:0]            cnt_reg,     cnt_next;
  iwr_state_t            state_reg,   state_next;
  iwr_ret_t              ret_reg,     ret_next;
  logic [PC_W-1:0]       stack_reg [STACK_DEPTH];
  logic [PC_W-1:0]       stack_next [STACK_DEPTH];

  iwr_bus_req_t          bus;
  logic [NV-1:0]         flags;
  logic [NV-1:0]         flag_rise;
  logic [NV-1:0]         hw_clr;
  logic [NUM_SUB-1:0]    sub_flags;
  logic [NUM_SUB-1:0]    sub_rise;
  logic [NV-1:0]         eligible;
  logic                  entry;
  logic                  full;
  logic [NUM_EVENTS-1:0] events;

  // ----------------------------------------------------------------
  // bus request decode
  // ----------------------------------------------------------------
  // byte lane 0 carries every register; other lanes are ignored
  always_comb begin
    bus.rd  = WB_CYC_I & WB_STB_I & ~ack_reg & ~WB_WE_I;
    bus.wr  = WB_CYC_I & WB_STB_I & ~ack_reg & WB_WE_I & WB_SEL_I[0];
    bus.adr = WB_ADR_I;
    bus.dat = WB_DAT_I[7:0];
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // set path on free-running clock
  // only the core clock stops in sleep; this block keeps CLOCK_I so edge and supply flags still set
  // grouped flag from sources
  iwr_flag_bank #(
    .W (NV)
  ) u_flags (
    .clk_i    (CLOCK_I),
    .rst_i    (RESET_I),
    .set_i    ({|sub_rise, SRC_SET_I}),
    .hw_clr_i (hw_clr),
    .sw_we_i  (bus.wr && (bus.adr == OFS_FLAGS)),
    .sw_dat_i (bus.dat[NV-1:0]),
    .flag_o   (flags),
    .rise_o   (flag_rise)
  );

  // grouped sources never cleared by service
  iwr_flag_bank #(
    .W (NUM_SUB)
  ) u_subflags (
    .clk_i    (CLOCK_I),
    .rst_i    (RESET_I),
    .set_i    (SUB_SET_I),
    .hw_clr_i ('0),
    .sw_we_i  (bus.wr && (bus.adr == OFS_SUBFLAGS)),
    .sw_dat_i (bus.dat[NUM_SUB-1:0]),
    .flag_o   (sub_flags),
    .rise_o   (sub_rise)
  );

  // ----------------------------------------------------------------
  // arbitration, stack and return sequencing
  // ----------------------------------------------------------------
  assign full  = (sp_reg == SP_FULL);
  assign entry = vreq_reg & VEC_ACK_I;

  always_comb begin
    hw_clr     = '0;
    gie_next   = gie_reg;
    vreq_next  = 1'b0;
    vidx_next  = vidx_reg;
    done_next  = 1'b0;
    rpc_next   = rpc_reg;
    sp_next    = sp_reg;
    cnt_next   = cnt_reg;
    state_next = state_reg;
    ret_next   = ret_reg;
    stack_next = stack_reg;
    events     = '0;
    wake_next  = 1'b0;
    eligible   = flags & en_reg & {NV{gie_reg & ~full & ~SLEEP_I & (state_reg == ST_IDLE)}};

    if (SLEEP_I && (|flag_rise || |sub_rise)) begin
      wake_next            = 1'b1;
      events[EV_WAKE_BIT]  = 1'b1;
    end

    if (bus.wr && (bus.adr == OFS_CTRL)) begin
      gie_next = bus.dat[CTRL_GIE_BIT];
    end

    if (entry) begin
      stack_next[sp_reg[$clog2(STACK_DEPTH)-1:0]] = PC_I;
      sp_next                                     = sp_reg + SP_ONE;
      hw_clr[vidx_reg]                            = 1'b1;
      gie_next                                    = 1'b0;
      events[EV_ENTRY_BIT]                        = 1'b1;
    end else if (CALL_I) begin
      // a call on a full stack is dropped and reported
      if (full) begin
        events[EV_OVERFLOW_BIT] = 1'b1;
      end else begin
        stack_next[sp_reg[$clog2(STACK_DEPTH)-1:0]] = PC_I;
        sp_next                                     = sp_reg + SP_ONE;
      end
    end else begin
      for (int i = NV - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          vreq_next = 1'b1;
          vidx_next = IW'(i);
        end
      end
    end

    case (state_reg)
      ST_IDLE: begin
        if ((RET_I || RETURN_FROM_INTERRUPT_I) && !entry && !CALL_I) begin
          vreq_next            = 1'b0;
          ret_next.busy        = 1'b1;
          ret_next.restore_gie = RETURN_FROM_INTERRUPT_I;
          cnt_next             = RETURN_LOAD;
          state_next           = ST_RETURN;
          // an empty stack returns address zero
          if (sp_reg != '0) begin
            rpc_next = stack_reg[SIW'(sp_reg - SP_ONE)];
            sp_next  = sp_reg - SP_ONE;
          end else begin
            rpc_next = '0;
          end
        end
      end
      ST_RETURN: begin
        cnt_next = cnt_reg - CNT_ONE;
        if (cnt_reg == CNT_ZERO) begin
          cnt_next              = CNT_ZERO;
          done_next             = 1'b1;
          events[EV_RETURN_BIT] = 1'b1;
          state_next            = ST_IDLE;
          ret_next.busy         = 1'b0;
          if (ret_reg.restore_gie) begin
            gie_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register file and interrupt output
  // ----------------------------------------------------------------
  always_comb begin
    ack_next    = WB_CYC_I & WB_STB_I & ~ack_reg;
    rdat_next   = rdat_reg;
    en_next     = en_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    if (bus.wr) begin
      if (bus.adr == OFS_ENABLE) begin
        en_next = bus.dat[NV-1:0];
      end else if (bus.adr == OFS_MASK) begin
        mask_next = bus.dat[NUM_EVENTS-1:0];
      end
    end
    if (bus.rd) begin
      rdat_next = DATA_ZERO;
      if (bus.adr == OFS_CTRL) begin
        rdat_next[CTRL_GIE_BIT] = gie_reg;
      end else if (bus.adr == OFS_ENABLE) begin
        rdat_next[NV-1:0] = en_reg;
      end else if (bus.adr == OFS_FLAGS) begin
        rdat_next[NV-1:0] = flags;
      end else if (bus.adr == OFS_SUBFLAGS) begin
        rdat_next[NUM_SUB-1:0] = sub_flags;
      end else if (bus.adr == OFS_STATUS) begin
        rdat_next[NUM_EVENTS-1:0] = status_reg;
        status_next               = '0;
      end else if (bus.adr == OFS_MASK) begin
        rdat_next[NUM_EVENTS-1:0] = mask_reg;
      end else if (bus.adr == OFS_STACK) begin
        rdat_next[SPW-1:0] = sp_reg;
      end
    end
    // an event in the clearing read cycle stays set
    status_next = status_next | events;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_reg    <= 1'b0;
      rdat_reg   <= DATA_ZERO;
      gie_reg    <= GIE_RESET;
      en_reg     <= '0;
      status_reg <= '0;
      mask_reg   <= '0;
      irq_reg    <= 1'b0;
      wake_reg   <= 1'b0;
      vreq_reg   <= 1'b0;
      vidx_reg   <= '0;
      done_reg   <= 1'b0;
      rpc_reg    <= '0;
      sp_reg     <= '0;
      cnt_reg    <= CNT_ZERO;
      state_reg  <= ST_IDLE;
      ret_reg    <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= '0;
      end
    end else begin
      ack_reg    <= ack_next;
      rdat_reg   <= rdat_next;
      gie_reg    <= gie_next;
      en_reg     <= en_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      wake_reg   <= wake_next;
      vreq_reg   <= vreq_next;
      vidx_reg   <= vidx_next;
      done_reg   <= done_next;
      rpc_reg    <= rpc_next;
      sp_reg     <= sp_next;
      cnt_reg    <= cnt_next;
      state_reg  <= state_next;
      ret_reg    <= ret_next;
      stack_reg  <= stack_next;
    end
  end

  // full flag is registered so the output stays a flip-flop
  logic full_reg;
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      full_reg <= 1'b0;
    end else begin
      full_reg <= (sp_next == SP_FULL);
    end
  end

  assign WB_ACK_O     = ack_reg;
  assign WB_DAT_O     = rdat_reg;
  assign WAKE_O       = wake_reg;
  assign VEC_REQ_O    = vreq_reg;
  assign VEC_IDX_O    = vidx_reg;
  assign RET_DONE_O   = done_reg;
  assign RET_PC_O     = rpc_reg;
  assign GIE_O        = gie_reg;
  assign STACK_FULL_O = full_reg;
  assign IRQ_O        = irq_reg;

endmodule

// file: verif/iwr_top_assertions.sv
// assertions on the iwr_top ports: bus answer, vectors, returns, wake-up
// assumes it is bound into every iwr_top instance
`timescale 1ns/1ps
module iwr_top_assertions (
  // clock, reset and bus
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // core side
  input wire logic SLEEP_I,
  input wire logic RET_I,
  input wire logic RETURN_FROM_INTERRUPT_I,
  input wire logic VEC_ACK_I,
  input wire logic WAKE_O,
  input wire logic VEC_REQ_O,
  input wire logic RET_DONE_O,
  input wire logic GIE_O,
  input wire logic STACK_FULL_O
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack held two cycles");
  property p_ack_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("bus ack without request");
  property p_vec_cond; $rose(VEC_REQ_O) |-> $past(GIE_O) && !$past(STACK_FULL_O); endproperty
  a_vec_cond: assert property (p_vec_cond) else $error("vector asked without enable or room");
  property p_vec_take; VEC_REQ_O && VEC_ACK_I |=> !GIE_O && !VEC_REQ_O; endproperty
  a_vec_take: assert property (p_vec_take) else $error("enable not cleared on entry");
  property p_no_vec_sleep; $past(SLEEP_I) |-> !VEC_REQ_O; endproperty
  a_no_vec_sleep: assert property (p_no_vec_sleep) else $error("vector asked in sleep");
  property p_wake_sleep; WAKE_O |-> $past(SLEEP_I) || $past(SLEEP_I, 2); endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
  // done is launched eight clocks after the accepted return, so it is sampled high one edge later
  property p_rtn_time; RET_DONE_O |-> $past(RET_I, 9) || $past(RETURN_FROM_INTERRUPT_I, 9); endproperty
  a_rtn_time: assert property (p_rtn_time) else $error("return length wrong");
  property p_rtn_intr; RET_DONE_O && $past(RETURN_FROM_INTERRUPT_I, 9) |-> GIE_O; endproperty
  a_rtn_intr: assert property (p_rtn_intr) else $error("enable not set by interrupt return");
  property p_rtn_plain; RET_DONE_O && $past(RET_I, 9) |-> $stable(GIE_O); endproperty
  a_rtn_plain: assert property (p_rtn_plain) else $error("plain return changed enable");

  c_vec: cover property (VEC_REQ_O && VEC_ACK_I);
  c_rtn: cover property (RET_DONE_O && GIE_O);
  c_wake: cover property (WAKE_O);
endmodule

bind iwr_top iwr_top_assertions iwr_top_assertions_inst (.*);

// file: verif/iwr_core_model.sv
// core model: takes vector requests at once or after three cycles
// assumes req_i is the registered vector request of the block
`timescale 1ns/1ps
module iwr_core_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // vector handshake
  input  wire logic req_i,
  input  wire logic slow_i,
  output logic      ack_o
);
  logic [1:0] wait_reg;
  // ------------------------------------------------------------
  // acknowledge
  // ------------------------------------------------------------
  // no call path in the model; the bench drives calls itself, also while a handler is in service
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      wait_reg <= 2'h0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
    end else if (req_i && (!slow_i || wait_reg == 2'h3)) begin
      ack_o    <= 1'b1;
      wait_reg <= 2'h0;
    end else if (req_i) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// file: verif/tb_iwr_top.sv
// bench for iwr_top: registers, vectors, returns, wake-up and interrupt output
// assumes the package, the design and the core model are compiled first
`timescale 1ns/1ps
module tb_iwr_top
  import iwr_pkg::*;
;
  typedef struct {
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } iwr_row_t;

  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        sleep = 1'b0, rtn_plain = 1'b0, rtn_intr = 1'b0, slow = 1'b0, call = 1'b0;
  logic        vack, ack, wake, vreq, rdone, gie, full, irq;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = DATA_ZERO;
  logic [31:0] rdat;
  logic [3:0]  src = 4'h0, sub = 4'h0;
  logic [11:0] pc = 12'h123;
  logic [11:0] rpc;
  logic [2:0]  vidx;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  iwr_row_t    rows [7] = '{
    '{OFS_CTRL, 32'h0000_0001, 32'h0000_0001}, '{OFS_CTRL, DATA_ZERO, DATA_ZERO},
    '{OFS_ENABLE, 32'h0000_001F, 32'h0000_001F}, '{OFS_ENABLE, DATA_ZERO, DATA_ZERO},
    '{OFS_MASK, 32'h0000_00FF, 32'h0000_000F}, '{8'h1C, 32'h0000_00FF, DATA_ZERO},
    '{OFS_STACK, 32'h0000_0003, DATA_ZERO}};

  iwr_top iwr_top_inst (
    .CLOCK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SRC_SET_I(src), .SUB_SET_I(sub),
    .SLEEP_I(sleep), .PC_I(pc), .CALL_I(call), .RET_I(rtn_plain), .RETURN_FROM_INTERRUPT_I(rtn_intr), .VEC_ACK_I(vack),
    .WAKE_O(wake), .VEC_REQ_O(vreq), .VEC_IDX_O(vidx), .RET_DONE_O(rdone), .RET_PC_O(rpc),
    .GIE_O(gie), .STACK_FULL_O(full), .IRQ_O(irq));
  iwr_core_model iwr_core_model_inst (.clk_i(clk), .rst_i(rst), .req_i(vreq), .slow_i(slow), .ack_o(vack));

  // ------------------------------------------------------------
  // clock, timeout and tasks
  // ------------------------------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  // the whole run needs about 240 cycles, so a normal run ends well before 20000
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, DATA_ZERO, q);
    chk(name, exp, q);
  endtask
  task automatic wait_vec(input logic [2:0] exp_idx);
    @(posedge clk);
    while (!(vreq === 1'b1 && vack === 1'b1)) @(posedge clk);
    chk("vector index", {29'h0, exp_idx}, {29'h0, vidx});
    @(posedge clk);
    chk("enable after entry", DATA_ZERO, {31'h0, gie});
  endtask
  task automatic do_rtn(input logic intr, input logic [11:0] exp_pc, input logic exp_gie);
    int n;
    rtn_plain <= !intr;
    rtn_intr  <= intr;
    @(posedge clk);
    rtn_plain <= 1'b0;
    rtn_intr  <= 1'b0;
    n = 0;
    @(posedge clk);
    chk("return address", {20'h0, exp_pc}, {20'h0, rpc});
    while (rdone !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("return clocks", RETURN_CLKS, 32'(n));
    chk("enable after return", {31'h0, exp_gie}, {31'h0, gie});
  endtask
  task automatic wake_count(input logic [3:0] s, input int exp);
    int k;
    k = 0;
    src <= s;
    @(posedge clk);
    src <= 4'h0;
    repeat (6) begin
      @(posedge clk);
      if (wake === 1'b1) k++;
    end
    chk("wake pulses", 32'(exp), 32'(k));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 28; a += 4) begin
      rd_chk("reset value", 8'(a), DATA_ZERO);
    end
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wdat);
      rd_chk("register", rows[i].adr, rows[i].exp);
    end
    wr(OFS_CTRL, 32'h0000_0001);
    src <= 4'h6;
    @(posedge clk);
    src <= 4'h0;
    repeat (6) @(posedge clk);
    chk("request while disabled", DATA_ZERO, {31'h0, vreq});
    rd_chk("flags held", OFS_FLAGS, 32'h0000_0006);
    wr(OFS_ENABLE, 32'h0000_001F);
    wait_vec(3'h1);
    rd_chk("flag cleared by entry", OFS_FLAGS, 32'h0000_0004);
    rd_chk("stack depth", OFS_STACK, 32'h0000_0001);
    pc   <= 12'h2A5;
    slow <= 1'b1;
    do_rtn(1'b1, 12'h123, 1'b1);
    wait_vec(3'h2);
    do_rtn(1'b0, 12'h2A5, 1'b0);
    wr(OFS_CTRL, 32'h0000_0001);
    sub <= 4'h4;
    @(posedge clk);
    sub <= 4'h0;
    wait_vec(3'h4);
    rd_chk("source flags kept", OFS_SUBFLAGS, 32'h0000_0004);
    rd_chk("grouped flag cleared", OFS_FLAGS, DATA_ZERO);
    wr(OFS_ENABLE, DATA_ZERO);
    wr(OFS_FLAGS, 32'h0000_0008);
    sleep <= 1'b1;
    wake_count(4'h8, 0);
    wake_count(4'h1, 1);
    sleep <= 1'b0;
    @(posedge clk);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    wr(OFS_MASK, DATA_ZERO);
    @(posedge clk);
    chk("irq masked", DATA_ZERO, {31'h0, irq});
    wr(OFS_MASK, 32'h0000_000F);
    @(posedge clk);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    rd_chk("status", OFS_STATUS, 32'h0000_0007);
    @(posedge clk);
    chk("irq cleared", DATA_ZERO, {31'h0, irq});
    call <= 1'b1;
    repeat (4) @(posedge clk);
    call <= 1'b0;
    rd_chk("stack depth full", OFS_STACK, 32'h0000_0004);
    chk("stack full flag", 32'h0000_0001, {31'h0, full});
    rd_chk("status overflow", OFS_STATUS, 32'h0000_0008);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_ENABLE, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("request while full", DATA_ZERO, {31'h0, vreq});
    do_rtn(1'b0, 12'h2A5, 1'b1);
    wait_vec(3'h0);
    // reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("full after reset", DATA_ZERO, {31'h0, full});
    chk("enable after reset", DATA_ZERO, {31'h0, gie});
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("stack after reset", OFS_STACK, DATA_ZERO);
    print_verdict();
  end
endmodule
